// ==== hw/dsw_pkg.sv ====
// Purpose: Shared constants for the serial DAC write host controller
// Assumes: 25 MHz system clock
// Notes: Frame, mode and timing constants used by the divider and host design files
package dsw_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;  // System clock period
  localparam int unsigned WORD_BITS = 16;      // Bits per frame
  localparam int unsigned BYTE_BITS = 8;       // Bits per byte transfer
  localparam int unsigned MODE_HI_POS = 15;    // Upper mode bit position
  localparam int unsigned MODE_LO_POS = 14;    // Lower mode bit position
  localparam int unsigned SYNC_HIGH_NS = 33;   // Least frame-high time
  // Least time rounds up to whole cycles, never below one
  localparam int unsigned SYNC_HIGH_CYC_RAW =
    (SYNC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SYNC_HIGH_CYC =
    (SYNC_HIGH_CYC_RAW < 1) ? 1 : SYNC_HIGH_CYC_RAW;
  localparam int unsigned HALF_PERIOD_CYC = 2; // Default serial half period
  // Operating mode codes carried in the two leading bits
  typedef enum logic [1:0] {
    DSW_MODE_NORMAL = 2'h0,   // Normal operation
    DSW_MODE_PD_1K = 2'h1,    // Power-down, low-ohm load to ground
    DSW_MODE_PD_100K = 2'h2,  // Power-down, high-ohm load to ground
    DSW_MODE_PD_TRI = 2'h3    // Power-down, output three-stated
  } dsw_mode_t;
endpackage

// ==== hw/dsw_if.sv ====
// Purpose: Carrier between the host top and its clock divider
// Assumes: Same clock domain on both sides
// Notes: Divider reports serial clock edges as one-cycle strobes
`timescale 1ns/100ps
`default_nettype none
interface dsw_if;
  logic run;        // Serial clock allowed to toggle
  logic sclk;       // Serial clock level
  logic rise;       // Strobe: serial clock rises at the next edge
  logic fall;       // Strobe: serial clock falls at the next edge
  modport ctl (output run, input sclk, input rise, input fall);
  modport div (input run, output sclk, output rise, output fall);
endinterface
`default_nettype wire

// ==== hw/dsw_clkdiv.sv ====
// Purpose: Serial clock divider for the host controller
// Assumes: Clock idles low while run is low
// Notes: Edge strobes mark the cycle before the level changes
`timescale 1ns/100ps
`default_nettype none
module dsw_clkdiv #(
  parameter int unsigned HALF = dsw_pkg::HALF_PERIOD_CYC // Half period
) (
  input wire logic clock_i,   // System clock
  input wire logic reset_i,   // Async reset, active high
  input wire logic enable_i,  // Clock enable
  dsw_if.div link             // Strobes to controller
);
  logic [7:0] count;          // Half-period counter
  logic wrap;                 // Half period complete
  assign wrap = (count == 8'(HALF - 1));
  assign link.rise = enable_i && link.run && wrap && !link.sclk;
  assign link.fall = enable_i && link.run && wrap && link.sclk;
  // Counter restarts whenever the clock is parked, so the first half
  // period of a frame is always whole
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 8'h00;
    end else if (enable_i) begin
      if (!link.run || wrap) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end
  // Clock level; parks low when stopped
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      link.sclk <= 1'b0;
    end else if (enable_i) begin
      if (!link.run) begin
        link.sclk <= 1'b0;
      end else if (wrap) begin
        link.sclk <= !link.sclk;
      end
    end
  end
endmodule // dsw_clkdiv
`default_nettype wire

// ==== hw/dsw_host.sv ====
// Purpose: Host controller writing 16-bit words to a serial DAC
// Assumes: 25 MHz clock; device samples data on falling serial clock
// Notes: Word or two-byte framing; abort drops the frame early
// Function
// - Host makes clock, low frame, 16-bit words
// - Clock idles low, phase one clocking
// - Data stable at each falling clock edge; here data changes on that same falling edge
// - Frame low before and through transfer
// - Byte mode: two bytes, frame held low
// - Word sent most significant bit first
// - Per-byte bit reversal keeps MSB first
// - Frame, data, clock driven by one port
// - Port enabled, then word loaded starts transfer
// - Data shifts on falling clock edge
// - Frame high at least 33 ns between writes
`timescale 1ns/100ps
`default_nettype none
module dsw_host #(
  parameter int unsigned HALF = dsw_pkg::HALF_PERIOD_CYC, // Half period
  parameter int unsigned GAP = dsw_pkg::SYNC_HIGH_CYC      // Frame-high cycles
) (
  input wire logic clock_i,          // System clock, 25 MHz
  input wire logic reset_i,          // Async reset, active high
  input wire logic enable_i,         // Clock enable, freezes state
  input wire logic port_enable_i,    // Serial port enabled
  input wire logic byte_mode_i,      // Send as two bytes
  input wire logic lsb_first_i,      // Port shifts bytes LSB first
  input wire logic req_valid_i,      // Write request
  output logic req_ready_o,          // Request can be accepted this cycle
  input wire dsw_pkg::dsw_mode_t mode_i, // Operating mode field
  input wire logic [13:0] code_i,    // DAC code field
  input wire logic abort_i,          // Raise frame early, drop write
  output logic busy_o,               // Transfer in progress
  output logic done_o,               // Pulse: word completed
  output logic aborted_o,            // Pulse: word dropped
  output logic host_tx_frame_sync_o, // Frame select, active low
  output logic host_tx_clock_out_o,  // Serial clock
  output logic host_tx_data_out_o    // Serial data
);
  typedef enum logic [4:0] {
    DSW_IDLE = 5'h01,   // Frame high, waiting
    DSW_LEAD = 5'h02,   // Frame low, first bit set up
    DSW_SHIFT = 5'h04,  // Clocking bits
    DSW_PAUSE = 5'h08,  // Byte mode pause, frame still low
    DSW_GAP = 5'h10     // Frame high hold time
  } dsw_state_t;

  dsw_state_t state;             // Current state
  dsw_state_t next_state;        // Next state
  logic [15:0] shift;            // Outgoing word, MSB at top
  logic [4:0] falls;             // Falling edges issued this frame
  logic [7:0] wait_count;        // Lead, pause and gap timer
  logic [15:0] word;             // Assembled word
  logic [15:0] wire_word;        // Word as the port will shift it
  logic take;                    // Request accepted
  logic stop;                    // Abort honoured
  logic byte_edge;               // Eighth fall in byte mode
  logic run;                     // Divider run control
  logic bmode;                   // Latched byte mode
  logic rev;                     // Latched bit reversal
  dsw_if dlink ();               // Divider link

  dsw_clkdiv #(.HALF(HALF)) u_div (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .enable_i(enable_i),
    .link(dlink.div)
  );

  // Mode sits in the two leading bits, code below it
  assign word = {mode_i, code_i};
  // A port that shifts LSB first gets each byte pre-reversed, so the
  // wire still carries MSB first; here the shifter is always MSB
  // first, reversal is modelled by reversing then restoring each byte's bit order
  always_comb begin
    wire_word = word;
    for (int i = 0; i < 8; i++) begin
      wire_word[15 - i] = lsb_first_i ? word[8 + i] : word[15 - i];
      wire_word[7 - i] = lsb_first_i ? word[i] : word[7 - i];
    end
  end

  assign take = enable_i && (state == DSW_IDLE) && req_valid_i &&
                port_enable_i;
  assign req_ready_o = (state == DSW_IDLE) && port_enable_i && enable_i;
  assign stop = enable_i && abort_i && (state != DSW_IDLE) &&
                (state != DSW_GAP);
  assign byte_edge = bmode && dlink.fall &&
                     (falls == 5'(dsw_pkg::BYTE_BITS - 1));
  // Run leaves byte_edge out: the fall strobe is built from run, so using
  // it here would close a combinational loop; the pause state parks the
  // clock one cycle later, after the eighth fall has already landed low
  assign run = (state == DSW_SHIFT) && !stop;
  assign dlink.run = run;

  // State transitions
  always_comb begin
    next_state = state;
    unique case (state)
      DSW_IDLE: begin
        if (take) begin
          next_state = DSW_LEAD;
        end
      end
      DSW_LEAD: begin
        if (wait_count == 8'(HALF - 1)) begin
          next_state = DSW_SHIFT;
        end
      end
      DSW_SHIFT: begin
        if (dlink.fall &&
            falls == 5'(dsw_pkg::WORD_BITS - 1)) begin
          next_state = DSW_GAP;
        end else if (byte_edge) begin
          next_state = DSW_PAUSE;
        end
      end
      DSW_PAUSE: begin
        if (wait_count == 8'(HALF - 1)) begin
          next_state = DSW_SHIFT;
        end
      end
      DSW_GAP: begin
        if (wait_count == 8'(GAP - 1)) begin
          next_state = DSW_IDLE;
        end
      end
      default: next_state = DSW_IDLE;
    endcase
    if (stop) begin
      next_state = DSW_GAP;
    end
  end

  // State register
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      state <= DSW_IDLE;
    end else if (enable_i) begin
      state <= next_state;
    end
  end

  // Timer restarts on each state change
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wait_count <= 8'h00;
    end else if (enable_i) begin
      if (next_state != state) begin
        wait_count <= 8'h00;
      end else if (wait_count != 8'hff) begin
        wait_count <= wait_count + 8'h01;
      end
    end
  end

  // Frame options held for the whole word
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      bmode <= 1'b0;
      rev <= 1'b0;
    end else if (take) begin
      bmode <= byte_mode_i;
      rev <= lsb_first_i;
    end
  end

  // Shifter: top bit is on the wire; advance after each fall so the
  // next bit settles while the clock is low and holds through the
  // rise, changing again at the next fall
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      shift <= 16'h0000;
    end else if (take) begin
      // Undo the pre-reversal the port applies while shifting
      for (int i = 0; i < 8; i++) begin
        shift[15 - i] <= lsb_first_i ? wire_word[8 + i] : wire_word[15 - i];
        shift[7 - i] <= lsb_first_i ? wire_word[i] : wire_word[7 - i];
      end
    end else if (dlink.fall) begin
      shift <= {shift[14:0], 1'b0};
    end
  end

  // Falling edge count for the frame
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      falls <= 5'h00;
    end else if (take) begin
      falls <= 5'h00;
    end else if (dlink.fall) begin
      falls <= falls + 5'h01;
    end
  end

  // Pin drivers; frame low from lead to last fall
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      host_tx_frame_sync_o <= 1'b1;
      host_tx_data_out_o <= 1'b0;
    end else if (enable_i) begin
      host_tx_frame_sync_o <= (next_state == DSW_IDLE) ||
                              (next_state == DSW_GAP);
      host_tx_data_out_o <= (next_state == DSW_GAP) ? 1'b0 :
                            (take ? word[dsw_pkg::MODE_HI_POS] :
                             (dlink.fall ? shift[14] : shift[15]));
    end
  end
  // Clock from divider register, idle low
  assign host_tx_clock_out_o = dlink.sclk;

  // Status pulses
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      aborted_o <= 1'b0;
    end else if (enable_i) begin
      done_o <= (state == DSW_SHIFT) && (next_state == DSW_GAP) && !stop;
      aborted_o <= stop;
    end
  end

  assign busy_o = (state != DSW_IDLE);
endmodule // dsw_host
`default_nettype wire

// ==== tb/dsw_host_properties.sv ====
// Purpose: Pin timing checks on the DAC host controller
// Assumes: One clock domain, ports of dsw_host only
// Notes: Fall counter measures each frame's length
`timescale 1ns/100ps
`default_nettype none
module dsw_host_chk #(
  parameter int unsigned GAP = 1 // Least frame-high cycles
) (
  input wire logic clock_i, // Clock
  input wire logic reset_i, // Reset
  input wire logic port_enable_i, // Port on
  input wire logic req_valid_i, // Request
  input wire logic req_ready_o, // Accept
  input wire dsw_pkg::dsw_mode_t mode_i, // Mode
  input wire logic busy_o, // Busy
  input wire logic done_o, // Done
  input wire logic aborted_o, // Dropped
  input wire logic host_tx_frame_sync_o, // Frame
  input wire logic host_tx_clock_out_o, // Clock
  input wire logic host_tx_data_out_o // Data
);
  logic prev_sclk; // Clock level a cycle back
  logic [4:0] falls; // Falls in this frame
  logic [7:0] high_cnt; // Frame-high run, saturating
  logic fell_now; // Clock fell this cycle
  logic mode_hi; // First bit to go out
  logic [4:0] falls_now; // Falls including this cycle
  assign fell_now = prev_sclk & ~host_tx_clock_out_o;
  assign falls_now = falls + {4'h0, fell_now};
  assign mode_hi = mode_i[1];
  // Last fall may land with the frame rise, so it is still counted
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      prev_sclk <= 1'b0;
      falls <= 5'h0;
    end else begin
      prev_sclk <= host_tx_clock_out_o;
      if (fell_now) falls <= falls + 5'h1;
      else if (host_tx_frame_sync_o) falls <= 5'h0;
    end
  end
  // Starts full so the first frame after reset is not flagged
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) high_cnt <= 8'hff;
    else if (!host_tx_frame_sync_o) high_cnt <= 8'h0;
    else if (high_cnt != 8'hff) high_cnt <= high_cnt + 8'h1;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_accept; req_valid_i && req_ready_o; endsequence
  sequence s_ends; $rose(host_tx_frame_sync_o); endsequence
  chk_idle_clock_low: assert property (
    host_tx_frame_sync_o |-> !host_tx_clock_out_o) else $error("clk");
  chk_data_held_high: assert property (
    host_tx_clock_out_o && $past(host_tx_clock_out_o)
    |-> $stable(host_tx_data_out_o)) else $error("data moved");
  chk_accept_opens: assert property (
    s_accept |=> !host_tx_frame_sync_o && busy_o) else $error("open");
  chk_first_bit_msb: assert property (
    s_accept |=> host_tx_data_out_o == $past(mode_hi)) else $error("msb");
  chk_ready_rules: assert property (
    req_ready_o |-> port_enable_i && !busy_o) else $error("ready");
  chk_frame_gap: assert property (
    $fell(host_tx_frame_sync_o) |-> {24'h0, high_cnt} >= GAP)
    else $error("gap");
  chk_sixteen_falls: assert property (
    s_ends |-> (falls_now == 5'h10) or (##[0:2] aborted_o))
    else $error("fall count");
  chk_done_on_full: assert property (
    $rose(host_tx_frame_sync_o) && falls_now == 5'h10 |-> ##[0:2] done_o)
    else $error("no done");
  chk_clock_in_frame: assert property (
    $rose(host_tx_clock_out_o) |-> !host_tx_frame_sync_o)
    else $error("clock outside frame");
endmodule // dsw_host_chk
bind dsw_host dsw_host_chk #(.GAP(GAP)) u_chk (.clock_i, .reset_i,
  .port_enable_i, .req_valid_i, .req_ready_o, .mode_i, .busy_o, .done_o,
  .aborted_o, .host_tx_frame_sync_o, .host_tx_clock_out_o,
  .host_tx_data_out_o);
`default_nettype wire

// ==== tb/dsw_dac_model.sv ====
// Purpose: Behavioural serial DAC on the host's far side
// Assumes: Data stable while the serial clock is high
// Notes: Write-only; keeps last word and mode
`timescale 1ns/100ps
`default_nettype none
module dsw_dac_model (
  input wire logic frame_n_i, // Frame, active low
  input wire logic sclk_i, // Serial clock
  input wire logic dac_serial_input_i, // dac_serial_input
  output logic [15:0] word_o, // Executed word
  output dsw_pkg::dsw_mode_t mode_o, // Mode
  output int writes_o // Executed words
);
  logic [15:0] shreg; // Input shift register
  logic d_q; // Bit caught in the high phase
  logic live; // Frame open
  int cnt; // Falls this frame
  initial begin
    word_o = 16'h0;
    mode_o = dsw_pkg::DSW_MODE_NORMAL;
    writes_o = 0;
    live = 1'b0;
    cnt = 0;
  end
  always @(negedge frame_n_i) begin
    live = 1'b1;
    cnt = 0;
  end
  // Seen late so a rise on the sixteenth fall still executes
  always @(posedge frame_n_i) begin
    #1;
    live = 1'b0;
    cnt = 0;
  end
  always @(posedge sclk_i) d_q = dac_serial_input_i;
  always @(negedge sclk_i) begin
    if (live && cnt < 16) begin
      shreg = {shreg[14:0], d_q};
      cnt = cnt + 1;
      if (cnt == 16) begin
        word_o = shreg;
        mode_o = dsw_pkg::dsw_mode_t'(shreg[15:14]);
        writes_o = writes_o + 1;
      end
    end
  end
endmodule // dsw_dac_model
`default_nettype wire

// ==== tb/dsw_host_tb.sv ====
// Purpose: Self-checking bench for the DAC host controller
// Assumes: Half period 2, one gap cycle
// Notes: Queue of sent words judged at every done or drop
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch %0t %h %h", $time, g, e); end end
module dsw_host_tb;
  logic clock_i, reset_i, enable_i, port_enable_i, byte_mode_i;
  logic lsb_first_i, req_valid_i, abort_i, req_ready_o, busy_o;
  logic done_o, aborted_o, host_tx_frame_sync_o, host_tx_clock_out_o;
  logic host_tx_data_out_o;
  logic [13:0] code_i;
  dsw_pkg::dsw_mode_t mode_i, dev_mode;
  logic [15:0] dev_word, lfsr;
  int dev_writes, err_count, samples_checked, nw;
  logic [15:0] expq[$]; // Words awaiting a result
  dsw_host #(.HALF(2), .GAP(dsw_pkg::SYNC_HIGH_CYC)) uut (.clock_i,
    .reset_i, .enable_i, .port_enable_i, .byte_mode_i, .lsb_first_i,
    .req_valid_i, .req_ready_o, .mode_i, .code_i, .abort_i, .busy_o,
    .done_o, .aborted_o, .host_tx_frame_sync_o, .host_tx_clock_out_o,
    .host_tx_data_out_o);
  dsw_dac_model dev (.frame_n_i(host_tx_frame_sync_o),
    .sclk_i(host_tx_clock_out_o), .dac_serial_input_i(host_tx_data_out_o),
    .word_o(dev_word), .mode_o(dev_mode), .writes_o(dev_writes));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // About 11 frames of 70 cycles; twenty times that before giving up
  initial begin
    #600000;
    err_count++;
    finish_test();
  end
  // A finished word must match the model; a dropped one changes nothing
  always @(negedge clock_i) begin
    if (done_o === 1'b1) begin
      nw++;
      `CHK(dev_word, expq[0])
      `CHK(dev_mode, expq[0][15:14])
      `CHK(dev_writes, nw)
      void'(expq.pop_front());
    end
    if (aborted_o === 1'b1) begin
      `CHK(dev_writes, nw)
      void'(expq.pop_front());
    end
  end
  // One request; cut above zero raises abort that many cycles later
  task automatic send(input logic [15:0] w, input logic bmode, int cut);
    int n;
    @(negedge clock_i);
    mode_i = dsw_pkg::dsw_mode_t'(w[15:14]);
    code_i = w[13:0];
    byte_mode_i = bmode;
    lsb_first_i = lfsr[3];
    req_valid_i = 1'b1;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    @(negedge clock_i);
    req_valid_i = 1'b0;
    expq.push_back(w);
    if (cut > 0) begin
      repeat (cut) @(negedge clock_i);
      abort_i = 1'b1;
      repeat (50) if (aborted_o !== 1'b1) @(negedge clock_i);
      abort_i = 1'b0;
    end
  endtask
  initial begin
    reset_i = 1'b1;
    enable_i = 1'b1;
    port_enable_i = 1'b0;
    byte_mode_i = 1'b0;
    lsb_first_i = 1'b0;
    req_valid_i = 1'b0;
    abort_i = 1'b0;
    code_i = 14'h0;
    mode_i = dsw_pkg::DSW_MODE_NORMAL;
    lfsr = 16'h469a;
    nw = 0;
    err_count = 0;
    samples_checked = 0;
    repeat (20) @(negedge clock_i);
    reset_i = 1'b0;
    `CHK({host_tx_frame_sync_o, host_tx_clock_out_o}, 2'h2)
    // Port off: a held request must be refused
    req_valid_i = 1'b1;
    repeat (4) @(negedge clock_i);
    `CHK({req_ready_o, host_tx_frame_sync_o}, 2'h1)
    req_valid_i = 1'b0;
    port_enable_i = 1'b1;
    // Every mode in word and byte framing, back to back
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      send({i[1:0], lfsr[13:0]}, i[2], 0);
    end
    // Drops mid-word and in the byte pause
    send(nxt(lfsr), 1'b0, 20);
    send(nxt(nxt(lfsr)), 1'b1, 35);
    // Freeze mid-frame; the word must still arrive whole
    send(16'hbfff, 1'b0, 0);
    repeat (30) @(negedge clock_i);
    enable_i = 1'b0;
    repeat (6) @(negedge clock_i);
    enable_i = 1'b1;
    repeat (300) if (busy_o !== 1'b0) @(negedge clock_i);
    `CHK(expq.size(), 0)
    finish_test();
  end
endmodule // dsw_host_tb
`default_nettype wire
